// *** logic/ioc_bank.sv ***
// pin and scan configuration register bank, top level
`timescale 1ns/10ps
`default_nettype none
module ioc_bank
  import ioc_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [7:0] pin_is_analog,
  input wire logic conv_done,
  input wire logic otf_load,
  input wire logic [3:0] otf_channel,
  output logic [3:0] conv_channel,
  output logic scan_busy
);
  logic [7:0] function_d;
  logic [7:0] function_q;
  logic [7:0] direction_d;
  logic [7:0] direction_q;
  logic [7:0] drive_d;
  logic [7:0] drive_q;
  logic [7:0] level_d;
  logic [7:0] level_q;
  logic [7:0] input_d;
  logic [7:0] input_q;
  logic [7:0] scan_ctrl_d;
  logic [7:0] scan_ctrl_q;
  logic [7:0] directed_d;
  logic [7:0] directed_q;
  logic [7:0] mask_d;
  logic [7:0] mask_q;
  logic [7:0] rd_data_d;
  logic [7:0] rd_data_q;
  logic rd_valid_d;
  logic rd_valid_q;

  // register writes; the input-level offset has no write path at all
  always_comb begin
    function_d = function_q;
    direction_d = direction_q;
    drive_d = drive_q;
    level_d = level_q;
    scan_ctrl_d = scan_ctrl_q;
    directed_d = directed_q;
    mask_d = mask_q;
    input_d = pin_in; // [R4]
    if (reg_wr_en) begin
      unique case (reg_addr)
        IOC_ADDR_PIN_FUNCTION: function_d = reg_wr_data; // [R13]
        IOC_ADDR_PIN_DIRECTION: direction_d = reg_wr_data; // [R1]
        IOC_ADDR_PIN_DRIVE_TYPE: drive_d = reg_wr_data; // [R2]
        IOC_ADDR_PIN_OUTPUT_LEVEL: level_d = reg_wr_data; // [R3]
        IOC_ADDR_SCAN_CONTROL: scan_ctrl_d = reg_wr_data & IOC_SCAN_CONTROL_KEEP; // [R10]
        // upper code bit kept as written; the host stays within 0 to 7
        IOC_ADDR_DIRECTED_CHANNEL: directed_d = reg_wr_data & IOC_DIRECTED_KEEP; // [R10] [R8]
        IOC_ADDR_SCAN_CHANNEL_MASK: mask_d = reg_wr_data; // [R12]
        default: ; // [R14]
      endcase
    end
  end

  // read mux, answer one cycle after the strobe; unmapped reads zero
  always_comb begin
    rd_valid_d = reg_rd_en;
    rd_data_d = rd_data_q;
    if (reg_rd_en) begin
      unique case (reg_addr)
        IOC_ADDR_PIN_FUNCTION: rd_data_d = function_q;
        IOC_ADDR_PIN_DIRECTION: rd_data_d = direction_q;
        IOC_ADDR_PIN_DRIVE_TYPE: rd_data_d = drive_q;
        IOC_ADDR_PIN_OUTPUT_LEVEL: rd_data_d = level_q;
        IOC_ADDR_PIN_INPUT_LEVEL: rd_data_d = input_q; // [R4]
        IOC_ADDR_SCAN_CONTROL: rd_data_d = scan_ctrl_q; // [R10]
        IOC_ADDR_DIRECTED_CHANNEL: rd_data_d = directed_q; // [R10]
        IOC_ADDR_SCAN_CHANNEL_MASK: rd_data_d = mask_q;
        default: rd_data_d = IOC_RST_BYTE;
      endcase
    end
  end

  // every register clears on reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      function_q <= IOC_RST_BYTE; // [R11]
      direction_q <= IOC_RST_BYTE;
      drive_q <= IOC_RST_BYTE;
      level_q <= IOC_RST_BYTE;
      input_q <= IOC_RST_BYTE;
      scan_ctrl_q <= IOC_RST_BYTE;
      directed_q <= IOC_RST_BYTE;
      mask_q <= IOC_RST_BYTE;
      rd_data_q <= IOC_RST_BYTE;
      rd_valid_q <= 1'b0;
    end else begin
      function_q <= function_d;
      direction_q <= direction_d;
      drive_q <= drive_d;
      level_q <= level_d;
      input_q <= input_d;
      scan_ctrl_q <= scan_ctrl_d;
      directed_q <= directed_d;
      mask_q <= mask_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign reg_rd_data = rd_data_q;
  assign reg_rd_valid = rd_valid_q;
  // analog routing follows the function bits; the host keeps [R9], nothing here checks it
  assign pin_is_analog = ~function_q; // [R13]

  ioc_pin_drive u_pin_drive (
    .core_clk(core_clk),
    .srst(srst),
    .pin_function(function_q),
    .pin_direction(direction_q),
    .output_drive_type(drive_q),
    .output_level(level_q),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n)
  );

  ioc_scan_seq u_scan_seq (
    .core_clk(core_clk),
    .srst(srst),
    .scan_mode_select(scan_ctrl_q[IOC_SCAN_MODE_LSB +: 2]),
    .scan_run(scan_ctrl_q[IOC_SCAN_RUN_BIT]),
    .scan_channel_mask(mask_q),
    .directed_channel_id(directed_q[IOC_CHW-1:0]),
    .conv_done(conv_done),
    .otf_load(otf_load),
    .otf_channel(otf_channel),
    .conv_channel(conv_channel),
    .scan_busy(scan_busy)
  );
endmodule // ioc_bank
`default_nettype wire

// *** logic/ioc_pkg.sv ***
// constants and encodings for the pin and scan configuration bank
// Operation
// R1: direction bit clear makes pin digital input, set makes digital output
// R2: drive-type bit 0 selects open-drain, 1 selects push-pull output driver
// R3: output pins are driven to the level held in the output-level register
// R4: input-level register reads back current pin levels and is read-only
// R5: in automatic mode scan-run set starts ascending scan, cleared stops it
// R6: scan-mode field 00 directed, 01 automatic, 10 on-the-fly, 11 reserved
// R7: in directed mode the next conversion uses the directed channel field
// R8: host writes only channel codes 0 to 7; codes 8 and up are reserved
// R9: host keeps the directed channel an analog input for valid results
// R10: reserved bits of scan-control and directed-channel registers read zero
// R11: all registers reset to zero: inputs, open-drain, stopped, channel 0
// R12: scan channel mask bit set includes that channel in automatic scan
// R13: pin-function bit 0 analog, 1 general-purpose; pin settings need 1
// R14: writes to the input-level register are ignored entirely
package ioc_pkg;
  localparam int unsigned IOC_NPIN = 8;
  localparam int unsigned IOC_CHW = 4;
  // register offsets
  localparam logic [7:0] IOC_ADDR_PIN_FUNCTION = 8'h05;
  localparam logic [7:0] IOC_ADDR_PIN_DIRECTION = 8'h07;
  localparam logic [7:0] IOC_ADDR_PIN_DRIVE_TYPE = 8'h09;
  localparam logic [7:0] IOC_ADDR_PIN_OUTPUT_LEVEL = 8'h0b;
  localparam logic [7:0] IOC_ADDR_PIN_INPUT_LEVEL = 8'h0d;
  localparam logic [7:0] IOC_ADDR_SCAN_CONTROL = 8'h10;
  localparam logic [7:0] IOC_ADDR_DIRECTED_CHANNEL = 8'h11;
  localparam logic [7:0] IOC_ADDR_SCAN_CHANNEL_MASK = 8'h12;
  // field layout
  localparam int unsigned IOC_SCAN_RUN_BIT = 4;
  localparam int unsigned IOC_SCAN_MODE_LSB = 0;
  localparam logic [7:0] IOC_SCAN_CONTROL_KEEP = 8'h13;
  localparam logic [7:0] IOC_DIRECTED_KEEP = 8'h0f;
  // values after reset
  localparam logic [7:0] IOC_RST_BYTE = 8'h00;
  localparam logic [3:0] IOC_RST_CHAN = 4'h0;
  // scan mode codes
  localparam logic [1:0] IOC_MODE_DIRECTED = 2'h0;
  localparam logic [1:0] IOC_MODE_AUTO = 2'h1;
  localparam logic [1:0] IOC_MODE_OTF = 2'h2;
  // channel before channel 0, so a search from here starts at 0
  localparam logic [3:0] IOC_CHAN_LAST = 4'h7;
  typedef enum logic [0:0] {IOC_SCN_IDLE, IOC_SCN_RUN} ioc_scan_state_t;
endpackage

// *** logic/ioc_pin_drive.sv ***
// per-pin output driver for the eight general-purpose pins
`timescale 1ns/10ps
`default_nettype none
module ioc_pin_drive
  import ioc_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] pin_function,
  input wire logic [7:0] pin_direction,
  input wire logic [7:0] output_drive_type,
  input wire logic [7:0] output_level,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n
);
  logic [7:0] out_d;
  logic [7:0] out_q;
  logic [7:0] oe_n_d;
  logic [7:0] oe_n_q;

  // one driver cell per pin
  genvar g;
  generate
    for (g = 0; g < IOC_NPIN; g++) begin : g_cell
      always_comb begin
        out_d[g] = output_level[g]; // [R3]
        oe_n_d[g] = 1'b1;
        // only a general-purpose pin set as output may drive
        if (pin_function[g] && pin_direction[g]) begin // [R13] [R1]
          if (output_drive_type[g]) begin
            oe_n_d[g] = 1'b0; // [R2]
          end else begin
            // open-drain pulls low only, the pull-up makes the high
            out_d[g] = 1'b0;
            oe_n_d[g] = output_level[g]; // [R2] [R3]
          end
        end
      end
    end
  endgenerate

  // registered so pads never see decode glitches
  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_q <= IOC_RST_BYTE;
      oe_n_q <= ~IOC_RST_BYTE; // [R11]
    end else begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe_n = oe_n_q;
endmodule // ioc_pin_drive
`default_nettype wire

// *** logic/ioc_scan_seq.sv ***
// channel sequencer choosing the analog input for the next conversion
`timescale 1ns/10ps
`default_nettype none
module ioc_scan_seq
  import ioc_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [1:0] scan_mode_select,
  input wire logic scan_run,
  input wire logic [7:0] scan_channel_mask,
  input wire logic [3:0] directed_channel_id,
  input wire logic conv_done,
  input wire logic otf_load,
  input wire logic [3:0] otf_channel,
  output logic [3:0] conv_channel,
  output logic scan_busy
);
  ioc_scan_state_t state_d;
  ioc_scan_state_t state_q;
  logic [3:0] chan_d;
  logic [3:0] chan_q;

  // next enabled channel above cur, wrapping; cur itself if mask is empty
  function automatic logic [3:0] next_chan(input logic [3:0] cur, input logic [7:0] mask);
    logic [3:0] res;
    logic found;
    logic [2:0] idx;
    res = cur;
    found = 1'b0;
    for (int k = 1; k <= 8; k++) begin
      idx = cur[2:0] + 3'(k);
      if (!found && mask[idx]) begin
        res = {1'b0, idx};
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // mode decode and scan stepping
  always_comb begin
    state_d = state_q;
    chan_d = chan_q;
    unique case (state_q)
      IOC_SCN_IDLE: begin
        if (scan_mode_select == IOC_MODE_AUTO && scan_run) begin // [R5] [R6]
          state_d = IOC_SCN_RUN;
          chan_d = next_chan(IOC_CHAN_LAST, scan_channel_mask); // [R12]
        end else if (scan_mode_select == IOC_MODE_DIRECTED) begin
          chan_d = directed_channel_id; // [R7]
        end else if (scan_mode_select == IOC_MODE_OTF && otf_load) begin
          chan_d = otf_channel; // [R6]
        end
      end
      IOC_SCN_RUN: begin
        if (scan_mode_select != IOC_MODE_AUTO || !scan_run) begin
          state_d = IOC_SCN_IDLE; // [R5]
        end else if (conv_done) begin
          chan_d = next_chan(chan_q, scan_channel_mask); // [R5] [R12]
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= IOC_SCN_IDLE;
      chan_q <= IOC_RST_CHAN; // [R11]
    end else begin
      state_q <= state_d;
      chan_q <= chan_d;
    end
  end

  assign conv_channel = chan_q;
  // an empty mask leaves nothing to scan
  assign scan_busy = (state_q == IOC_SCN_RUN) && (scan_channel_mask != IOC_RST_BYTE);
endmodule // ioc_scan_seq
`default_nettype wire

// *** verification/ioc_bank_checker.sv ***
// port assertions for the pin and scan configuration bank
`timescale 1ns/10ps
`default_nettype none
module ioc_bank_checker
  import ioc_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pin_is_analog,
  input wire logic conv_done,
  input wire logic otf_load,
  input wire logic [3:0] conv_channel,
  input wire logic scan_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // anything that may legally move the conversion channel
  wire logic cause;
  assign cause = reg_wr_en | conv_done | otf_load;
  sequence pins_still; $stable(pin_in) [*3]; endsequence
  sequence rd_of(logic [7:0] a); reg_rd_en && reg_addr == a; endsequence
  chk_read_answer: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");
  chk_no_stray: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("stray read valid");
  chk_data_holds: assert property (!reg_rd_valid |-> $stable(reg_rd_data))
    else $error("read data moved");
  chk_input_level: assert property ((pins_still ##0 rd_of(IOC_ADDR_PIN_INPUT_LEVEL))
    |=> reg_rd_data == $past(pin_in)) else $error("input level wrong");
  chk_rsv_scan: assert property (rd_of(IOC_ADDR_SCAN_CONTROL)
    |=> (reg_rd_data & ~IOC_SCAN_CONTROL_KEEP) == 8'h00) else $error("scan reserved set");
  chk_rsv_chan: assert property (rd_of(IOC_ADDR_DIRECTED_CHANNEL)
    |=> (reg_rd_data & ~IOC_DIRECTED_KEEP) == 8'h00) else $error("channel reserved set");
  chk_analog_quiet: assert property (|(pin_is_analog & ~pin_oe_n)
    |=> !(|(pin_is_analog & ~pin_oe_n))) else $error("analog pin driven");
  chk_pin_cause: assert property ($changed(pin_oe_n)
    |-> $past(reg_wr_en) || $past(reg_wr_en, 2)) else $error("pin drive moved alone");
  chk_chan_cause: assert property ($changed(conv_channel)
    |-> $past(cause) || $past(cause, 2) || $past(cause, 3)) else $error("channel moved alone");
  // a mask write shows next cycle, a run write needs one more for the state step
  chk_busy_start: assert property ($rose(scan_busy) |-> $past(reg_wr_en) || $past(reg_wr_en, 2))
    else $error("scan started alone");
  chk_scan_range: assert property (scan_busy |-> !conv_channel[3])
    else $error("scan channel out of range");
endmodule // ioc_bank_checker
bind ioc_bank ioc_bank_checker chk (.*);
`default_nettype wire

// *** verification/ioc_host_model.sv ***
// host controller model driving the register strobes
`timescale 1ns/10ps
`default_nettype none
module ioc_host_model (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end
  // released lines flip so a stale value is never trusted
  task automatic release_bus();
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~reg_addr;
    reg_wr_data = ~reg_wr_data;
  endtask
  // one write, held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    release_bus();
  endtask
  // one read; the answer stands in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    ok = reg_rd_valid;
    d = reg_rd_data;
    release_bus();
  endtask
endmodule // ioc_host_model
`default_nettype wire

// *** verification/ioc_bank_bench.sv ***
// self-checking bench for the pin and scan configuration bank
`timescale 1ns/10ps
`default_nettype none
module ioc_bank_bench
  import ioc_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, pin_out, pin_oe_n, pin_is_analog;
  logic [7:0] pin_in = 8'h00;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, scan_busy;
  logic conv_done = 1'b0;
  logic otf_load = 1'b0;
  logic [3:0] otf_channel = 4'h0;
  logic [3:0] conv_channel;
  int errors = 0;
  int num_checks = 0;
  // 50 ns clock
  always #25 core_clk = ~core_clk;
  ioc_bank dut (.*);
  ioc_host_model host (.*);
  // case inequality so an unknown never matches
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic summarize();
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    check({7'h00, ok}, 8'h01, "read valid");
    check(d, exp, msg);
  endtask
  // converter pulses last one cycle, then a cycle for the channel to land
  task automatic strobe(input logic d, input logic o);
    conv_done = d;
    otf_load = o;
    @(negedge core_clk);
    conv_done = 1'b0;
    otf_load = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 8 && scan_busy !== lvl; i++) @(negedge core_clk);
    if (scan_busy !== lvl) begin
      errors++;
      summarize();
    end
  endtask
  // pin drives only as a general-purpose output; open-drain never drives high
  function automatic logic [15:0] pin_exp(input logic [7:0] f, dir, drv, lvl);
    logic [7:0] en;
    en = f & dir;
    return {~(en & (drv | ~lvl)), en & lvl & drv};
  endfunction
  task automatic t_reset();
    logic [7:0] a[9] = '{8'h05, 8'h07, 8'h09, 8'h0b, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h00};
    foreach (a[i]) rd_chk(a[i], 8'h00, "reset value");
    check(pin_oe_n, 8'hff, "reset drive");
    check(pin_is_analog, 8'hff, "reset analog");
    check({4'h0, conv_channel}, 8'h00, "reset channel");
  endtask
  task automatic t_pins();
    logic [7:0] v[2][4] = '{'{8'hfe, 8'hf1, 8'ha5, 8'h6c}, '{8'h0f, 8'h3f, 8'h5a, 8'h93}};
    logic [15:0] e;
    foreach (v[k]) begin
      host.wr(8'h05, v[k][0]);
      host.wr(8'h07, v[k][1]);
      host.wr(8'h09, v[k][2]);
      host.wr(8'h0b, v[k][3]);
      @(negedge core_clk);
      e = pin_exp(v[k][0], v[k][1], v[k][2], v[k][3]);
      check(pin_oe_n, e[15:8], "pin enables");
      check(pin_out & ~pin_oe_n, e[7:0], "pin levels");
      check(pin_is_analog, ~v[k][0], "analog map");
      rd_chk(8'h0b, v[k][3], "level readback");
    end
  endtask
  // a write to the input levels is dropped and leaves the pins alone
  task automatic t_input();
    logic [7:0] oe;
    pin_in = 8'ha6;
    oe = pin_oe_n;
    host.wr(8'h0d, 8'h5b);
    rd_chk(8'h0d, 8'ha6, "input level");
    check(pin_oe_n, oe, "pins after write");
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      host.wr(8'h10, 8'hec | 8'(m));
      rd_chk(8'h10, 8'(m), "scan mode");
    end
    host.wr(8'h11, 8'hf7);
    rd_chk(8'h11, 8'h07, "directed id");
  endtask
  task automatic t_directed();
    host.wr(8'h05, 8'h00);
    host.wr(8'h10, 8'h00);
    for (int c = 0; c < 8; c += 3) begin
      host.wr(8'h11, 8'(c));
      @(negedge core_clk);
      check({4'h0, conv_channel}, 8'(c), "directed channel");
    end
  endtask
  // ascend through the mask, wrap, ignore strays, stop, then on-the-fly
  task automatic t_auto();
    host.wr(8'h12, 8'h0a);
    host.wr(8'h10, 8'h11);
    wait_busy(1'b1);
    check({4'h0, conv_channel}, 8'h01, "first scan channel");
    strobe(1'b1, 1'b0);
    check({4'h0, conv_channel}, 8'h03, "next scan channel");
    otf_channel = 4'h6;
    strobe(1'b1, 1'b1);
    check({4'h0, conv_channel}, 8'h01, "wrapped channel");
    host.wr(8'h10, 8'h01);
    wait_busy(1'b0);
    strobe(1'b1, 1'b0);
    check({4'h0, conv_channel}, 8'h01, "stopped channel");
    host.wr(8'h10, 8'h02);
    strobe(1'b0, 1'b1);
    check({4'h0, conv_channel}, 8'h06, "on-the-fly channel");
  endtask
  // main sequence, ending with a second reset after the last test and a fresh reset check
  initial begin
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    t_reset();
    t_pins();
    t_input();
    t_modes();
    t_directed();
    t_auto();
    // input levels are live, so the pins must be quiet for the zero readback
    pin_in = 8'h00;
    srst = 1'b1;
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    t_reset();
    summarize();
  end
endmodule // ioc_bank_bench
`default_nettype wire
